// *** src/sarc_clk_if.sv ***
// Conversion clock signals between the clock generator and the sequencer.
`timescale 1ns/100ps
`default_nettype none
interface sarc_clk_if;
    logic tick;
    logic lvl;
    logic int_sel;
    logic restart;
    modport gen (input int_sel, input restart, output tick, output lvl);
    modport usr (output int_sel, output restart, input tick, input lvl);
endinterface
`default_nettype wire

// *** src/sarc_clkgen.sv ***
// Conversion clock source: internal divider or synchronised external clock.
`timescale 1ns/100ps
`default_nettype none
module sarc_clkgen import sarc_pkg::*; #(
    parameter logic [7:0] DIV = 8'(INT_DIV)
) (
    // System
    input wire logic clk,
    input wire logic resetn,
    // External clock pin
    input wire logic ext_clk_pin,
    // Clock to the sequencer
    sarc_clk_if.gen cif
);

    localparam logic [7:0] HALF = {1'b0, DIV[7:1]};

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [7:0] cnt;
        logic ilvl;
    } sarc_clkgen_t;

    sarc_clkgen_t r;
    sarc_clkgen_t n;
    logic int_tick;

    ////////////////////////////////////////////////////////////////////////
    assign int_tick = !cif.restart && (r.cnt == DIV - 8'h01);

    always_comb begin
        n = r;
        n.s1 = ext_clk_pin;
        n.s2 = r.s1;
        n.s3 = r.s2;
        // A restart begins in the low half so the first tick is a true edge.
        if (cif.restart) begin
            n.cnt = HALF;
        end else if (int_tick) begin
            n.cnt = 8'h00;
        end else begin
            n.cnt = r.cnt + 8'h01;
        end
        n.ilvl = (n.cnt < HALF);
    end

    assign cif.tick = cif.int_sel ? int_tick : (r.s2 & ~r.s3);
    assign cif.lvl = cif.int_sel ? r.ilvl : r.s2;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '{s1: 1'b0, s2: 1'b0, s3: 1'b0, cnt: 8'h00, ilvl: 1'b0};
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_int_gap;
        cif.int_sel && cif.tick |=> (!cif.tick) [*8];
    endproperty
    a_int_gap: assert property (p_int_gap) else $error("internal ticks too close");

    property p_ext_edge;
        !cif.int_sel && cif.tick |-> cif.lvl ##1 !cif.tick;
    endproperty
    a_ext_edge: assert property (p_ext_edge) else $error("external tick not on a rise");

endmodule
`default_nettype wire

// *** src/sarc_pkg.sv ***
// Shared constants and types of the converter control block.
package sarc_pkg;

    // Result width and resolution selection.
    localparam int SARC_BITS = 12;
    localparam logic [3:0] RES_FULL = 4'hC;

    // Timing.
    localparam int CLK_HZ = 40000000;
    localparam int CLK_NS = 25;
    localparam int INT_OSC_HZ = 545000;
    localparam int INT_DIV = CLK_HZ / INT_OSC_HZ;
    localparam int CONV_MAX_NS = 25000;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_NS;

    // Register offsets (byte addresses).
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_RES = 8'h0C;

    // Control fields.
    localparam int CTRL_RES_LSB = 0;
    localparam int CTRL_INT_BIT = 4;
    localparam int CTRL_OBN_BIT = 5;
    localparam logic [5:0] CTRL_RST = 6'h3F;

    // Status, mask and result fields.
    localparam int STS_DONE_BIT = 0;
    localparam int STS_IGN_BIT = 1;
    localparam logic [1:0] STS_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam int RES_BUSY_BIT = 12;
    localparam logic [11:0] PDATA_RST = 12'hFFF;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARM = 3'b010,
        ST_RUN = 3'b100
    } sarc_state_t;

endpackage

// *** src/sarc_top.sv ***
// Successive-approximation conversion control with register port and pins.
//
// Notes on behaviour
// - Twelve-bit result, one bit per step, MSB first.
// - Internal clock finishes full conversion within 25 us.
// - Host may truncate conversion below twelve bits.
// - External clock may replace the internal one.
// - Parallel, serial, clock and status outputs provided.
// - Unconnected inputs read as logic high.
// - Own approximation register and 545 kHz clock.
// - Parallel code complementary straight, offset or twos.
// - Serial is NRZ, straight or offset, no twos.
// - Twelve data bits plus clock, status, serial out.
// - Lowest input gives all ones.
// - All zeros marks the top of range.
// - Bit n decided on clock pulse n plus one.
// - Convert pulses during conversion are ignored.
// - Serial data only during conversion, MSB first.
// - Codes active low; inverted MSB output separately.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module sarc_top import sarc_pkg::*; (
    // System
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // Converter pins in
    input wire logic convert_pin,
    input wire logic ext_clk_pin,
    input wire logic comp_hi_pin,
    // Converter pins out
    output logic [11:0] dac_code,
    output logic [11:0] data_n,
    output logic msb_inv,
    output logic status,
    output logic clock_out,
    output logic serial_out
);

    typedef struct packed {
        sarc_state_t st;
        logic [1:0] cv_sy;
        logic cv_d;
        logic [1:0] cmp_sy;
        logic [11:0] sar;
        logic [3:0] step;
        logic [11:0] pdata;
        logic msbi;
        logic busy;
        logic ckout;
        logic ser;
        logic [5:0] ctrl;
        logic [1:0] sts;
        logic [1:0] mask;
        logic [31:0] rdata;
        logic restart;
    } sarc_main_t;

    localparam sarc_main_t MAIN_RST = '{
        st: ST_IDLE,
        cv_sy: 2'h0,
        cv_d: 1'b0,
        cmp_sy: 2'h0,
        sar: 12'h000,
        step: 4'h0,
        pdata: PDATA_RST,
        msbi: 1'b0,
        busy: 1'b0,
        ckout: 1'b0,
        ser: 1'b1,
        ctrl: CTRL_RST,
        sts: STS_RST,
        mask: MASK_RST,
        rdata: 32'h0000_0000,
        restart: 1'b0
    };

    // Open or zero selections mean full resolution, like a floating pin.
    function automatic logic [3:0] res_of(input logic [3:0] f);
        return (f == 4'h0 || f > RES_FULL) ? RES_FULL : f;
    endfunction

    sarc_main_t r;
    sarc_main_t n;
    logic cv_rise;
    logic done_ev;
    logic ign_ev;
    logic sts_rd;
    logic [3:0] res;
    logic [3:0] dec_idx;

    sarc_clk_if cif ();

    sarc_clkgen u_clkgen (
        .clk(clk),
        .resetn(resetn),
        .ext_clk_pin(ext_clk_pin),
        .cif(cif.gen)
    );

    ////////////////////////////////////////////////////////////////////////
    assign cv_rise = r.cv_sy[1] & ~r.cv_d;
    assign res = res_of(r.ctrl[CTRL_RES_LSB +: 4]);
    assign dec_idx = RES_FULL - r.step;
    assign sts_rd = reg_rd && (reg_addr == ADDR_STS);
    assign cif.int_sel = r.ctrl[CTRL_INT_BIT];
    assign cif.restart = r.restart;

    always_comb begin
        n = r;
        done_ev = 1'b0;
        ign_ev = 1'b0;
        n.cv_sy = {r.cv_sy[0], convert_pin};
        n.cv_d = r.cv_sy[1];
        n.cmp_sy = {r.cmp_sy[0], comp_hi_pin};
        n.restart = 1'b0;
        unique case (r.st)
            ST_IDLE: begin
                if (cv_rise) begin
                    n.st = ST_ARM;
                    n.busy = 1'b1;
                    n.sar = 12'h000;
                    n.step = 4'h0;
                    n.ser = 1'b1;
                end
            end
            ST_ARM: begin
                // The pulse clears the sequencer; work starts when it ends.
                if (!r.cv_sy[1]) begin
                    n.st = ST_RUN;
                    n.restart = 1'b1;
                end
            end
            ST_RUN: begin
                if (cv_rise) begin
                    ign_ev = 1'b1;
                end
                if (cif.tick) begin
                    n.step = r.step + 4'h1;
                    if (r.step == 4'h0) begin
                        n.sar[11] = 1'b1;
                    end else begin
                        n.sar[dec_idx] = r.cmp_sy[1];
                        n.ser = ~r.cmp_sy[1];
                        if (r.step == res) begin
                            n.st = ST_IDLE;
                            n.busy = 1'b0;
                            done_ev = 1'b1;
                            n.pdata = ~n.sar;
                            // Offset binary becomes twos complement by its MSB.
                            if (!r.ctrl[CTRL_OBN_BIT]) begin
                                n.pdata[11] = n.sar[11];
                            end
                            n.msbi = n.sar[11];
                        end else begin
                            n.sar[dec_idx - 4'h1] = 1'b1;
                        end
                    end
                end
            end
            default: begin
                n.st = ST_IDLE;
                n.busy = 1'b0;
            end
        endcase
        n.ckout = (r.st == ST_RUN) && cif.lvl;

        // Register port: a hardware event wins over the clearing read.
        n.sts = (r.sts & ~{2{sts_rd}}) | {ign_ev, done_ev};
        n.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_CTRL: n.rdata[5:0] = r.ctrl;
                ADDR_STS: n.rdata[1:0] = r.sts;
                ADDR_MASK: n.rdata[1:0] = r.mask;
                ADDR_RES: n.rdata[12:0] = {r.busy, r.pdata};
                default: n.rdata = 32'h0000_0000;
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                ADDR_CTRL: n.ctrl = reg_wdata[5:0];
                ADDR_MASK: n.mask = reg_wdata[1:0];
                default: n.mask = r.mask;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= MAIN_RST;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign reg_rdata = r.rdata;
    assign irq = |(r.sts & r.mask);
    assign dac_code = r.sar;
    assign data_n = r.pdata;
    assign msb_inv = r.msbi;
    assign status = r.busy;
    assign clock_out = r.ckout;
    assign serial_out = r.ser;

    ////////////////////////////////////////////////////////////////////////
    // Helper for the conversion time check: cycles spent in the run state.
    localparam int CONV_LIM = CONV_MAX_CYC;
    logic [10:0] run_cnt;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_cnt <= 11'h000;
        end else if (r.st != ST_RUN) begin
            run_cnt <= 11'h000;
        end else if (run_cnt != 11'h7FF) begin
            run_cnt <= run_cnt + 11'h001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_start;
        r.st == ST_IDLE && cv_rise;
    endsequence

    sequence s_last;
        r.st == ST_RUN && cif.tick && r.step != 4'h0 && r.step == res;
    endsequence

    sequence s_first;
        r.st == ST_RUN && cif.tick && r.step == 4'h0;
    endsequence

    property p_busy_rise;
        s_start |=> status && r.st == ST_ARM;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("status not raised at start");

    property p_end;
        s_last |=> !status && r.st == ST_IDLE && r.sts[STS_DONE_BIT];
    endproperty
    a_end: assert property (p_end) else $error("conversion did not end on last pulse");

    property p_msb_first;
        s_first |=> dac_code == 12'h800;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first trial is not the MSB");

    property p_decide_msb;
        r.st == ST_RUN && cif.tick && r.step == 4'h1
            |=> dac_code[11] == $past(r.cmp_sy[1]) && r.step == 4'h2;
    endproperty
    a_decide_msb: assert property (p_decide_msb) else $error("MSB decided wrongly");

    property p_ignore;
        r.st == ST_RUN && cv_rise |=> r.st != ST_ARM && r.sts[STS_IGN_BIT];
    endproperty
    a_ignore: assert property (p_ignore) else $error("convert during run not ignored");

    property p_serial;
        r.st == ST_RUN && cif.tick && r.step != 4'h0
            |=> serial_out == !$past(r.cmp_sy[1]);
    endproperty
    a_serial: assert property (p_serial) else $error("serial bit wrong");

    // Checked at completion, because the code select may be rewritten while idle.
    property p_ctc;
        s_last |=> (data_n[11] == msb_inv) == !$past(r.ctrl[CTRL_OBN_BIT]);
    endproperty
    a_ctc: assert property (p_ctc) else $error("MSB inversion wrong for code");

    property p_short;
        s_last ##1 (res == 4'h8 && $stable(r.ctrl)) |-> data_n[3:0] == 4'hF;
    endproperty
    a_short: assert property (p_short) else $error("truncated bits not all ones");

    property p_conv_time;
        cif.int_sel && r.st == ST_RUN |-> run_cnt < 11'(CONV_LIM);
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("conversion too slow");

    property p_clock_out;
        r.st != ST_RUN |=> !clock_out;
    endproperty
    a_clock_out: assert property (p_clock_out) else $error("clock out outside run");

    property p_busy_run;
        r.st == ST_RUN |-> status;
    endproperty
    a_busy_run: assert property (p_busy_run) else $error("status low during run");

endmodule
`default_nettype wire

// *** verification/sarc_host_model.sv ***
// Host-side model: issues convert pulses and captures the serial result.
`timescale 1ns/100ps
`default_nettype none
module sarc_host_model #(
    parameter int PULSE_CYC = 8
) (
    // System
    input wire logic clk,
    input wire logic resetn,
    // Bench control
    input wire logic go,
    // Converter pins
    output logic convert_pin,
    input wire logic status,
    input wire logic [11:0] dac_code,
    input wire logic serial_out,
    // Captured serial word, first bit ends up most significant
    output logic [11:0] ser_word,
    output logic [3:0] ser_cnt
);
    int left;
    logic [11:0] dac_q;
    logic status_q;

    ////////////////////////////////////////////////////////////////////////////////////////
    // A pulse of 200 ns sits inside the window that keeps the timing guaranteed.
    // A new trial bit appears at every tick but the last, the first setting the MSB, so a change of
    // the trial code from a non-zero code marks a freshly decided bit; the last one is taken at the end.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            convert_pin <= 1'b0;
            left <= 0;
            dac_q <= 12'h000;
            status_q <= 1'b0;
            ser_word <= 12'h000;
            ser_cnt <= 4'h0;
        end else begin
            dac_q <= dac_code;
            status_q <= status;
            if (go) begin
                convert_pin <= 1'b1;
                left <= PULSE_CYC;
            end else if (left > 1) begin
                left <= left - 1;
            end else begin
                convert_pin <= 1'b0;
                left <= 0;
            end
            if (status && !status_q) begin
                ser_word <= 12'h000;
                ser_cnt <= 4'h0;
            end else if (status && dac_code != dac_q && dac_q != 12'h000) begin
                ser_word <= {ser_word[10:0], serial_out};
                ser_cnt <= ser_cnt + 4'h1;
            end else if (!status && status_q) begin
                ser_word <= {ser_word[10:0], serial_out};
                ser_cnt <= ser_cnt + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench of the converter control block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import sarc_pkg::*;
    typedef struct packed {
        logic [3:0] res;
        logic int_clk;
        logic obn;
        logic [11:0] vin;
        logic [11:0] exp_n;
    } sarc_row_t;

    logic clk, resetn, reg_wr, reg_rd, irq, convert_pin, ext_clk_pin, comp_hi_pin;
    logic msb_inv, status, clock_out, serial_out, go;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [11:0] dac_code, data_n, ser_word, vin;
    logic [3:0] ser_cnt;
    int num_errors, n_tests, cyc;
    sarc_row_t rows [0:6] = '{'{4'hC, 1'b1, 1'b1, 12'h000, 12'hFFF},
        '{4'hC, 1'b1, 1'b1, 12'hFFF, 12'h000}, '{4'hC, 1'b1, 1'b0, 12'h800, 12'hFFF},
        '{4'h8, 1'b1, 1'b1, 12'hA5C, 12'h5AF}, '{4'hC, 1'b0, 1'b1, 12'h123, 12'hEDC},
        '{4'h1, 1'b0, 1'b0, 12'h9AB, 12'hFFF}, '{4'h0, 1'b1, 1'b1, 12'h3C3, 12'hC3C}};

    sarc_top dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .convert_pin(convert_pin), .ext_clk_pin(ext_clk_pin), .comp_hi_pin(comp_hi_pin),
        .dac_code(dac_code), .data_n(data_n), .msb_inv(msb_inv), .status(status),
        .clock_out(clock_out), .serial_out(serial_out));
    sarc_host_model host_u (.clk(clk), .resetn(resetn), .go(go), .convert_pin(convert_pin),
        .status(status), .dac_code(dac_code), .serial_out(serial_out),
        .ser_word(ser_word), .ser_cnt(ser_cnt));

    ////////////////////////////////////////////////////////////////////////////////////////
    // Ideal comparator: the input is at or above the trial code.
    always @(posedge clk) begin
        comp_hi_pin <= (vin >= dac_code);
    end

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // The external clock runs free and out of phase with the system clock.
    initial begin
        ext_clk_pin = 1'b0;
        #37;
        forever #100 ext_clk_pin = ~ext_clk_pin;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_status(input logic v, input int bound);
        cyc = 0;
        while (status !== v) begin
            @(negedge clk);
            cyc++;
            if (cyc > bound) begin
                num_errors++;
                $display("[ERR] %0t status wait timed out", $time);
                tally_and_finish();
            end
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic pulse_go();
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask

    // One conversion: ign adds a convert pulse in mid-run, msk is the expected irq.
    task automatic run_conv(input sarc_row_t r, input logic ign, input logic msk);
        int w;
        int pre;
        logic [11:0] e;
        logic [11:0] s;
        w = (r.res == 4'h0 || r.res > 4'hC) ? 12 : int'(r.res);
        // Cycles of the busy time that pass before the final wait starts counting.
        pre = ign ? 102 : 0;
        e = r.exp_n;
        s = (~r.vin) >> (12 - w);
        reg_write(ADDR_CTRL, {26'h0, r.obn, r.int_clk, r.res});
        vin = r.vin;
        pulse_go();
        wait_status(1'b1, 10);
        if (ign) begin
            repeat (100) @(posedge clk);
            pulse_go();
        end
        wait_status(1'b0, 2000);
        cyc += pre;
        if (r.int_clk)
            check(32'(cyc >= w * INT_DIV && cyc <= (w + 1) * INT_DIV + 20), 1, "time");
        else
            check(32'(cyc < CONV_MAX_CYC / 4), 1, "ext time");
        @(negedge clk);
        check(32'(data_n), 32'(e), "parallel");
        check(32'(msb_inv), 32'(r.vin[11]), "msb out");
        check(32'(clock_out), 0, "clock idle");
        check(32'(ser_cnt), 32'(w), "serial count");
        check(32'(ser_word), 32'(s), "serial word");
        check(32'(irq), 32'(msk), "irq set");
        reg_read(ADDR_RES, rd);
        check(rd, {19'h0, 1'b0, e}, "result reg");
        reg_read(ADDR_STS, rd);
        check(rd, ign ? 32'h3 : 32'h1, "status reg");
        check(32'(irq), 0, "irq clear");
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        num_errors = 0;
        n_tests = 0;
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        go = 1'b0;
        vin = 12'h000;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        check({data_n, status, serial_out, clock_out, irq}, {12'hFFF, 4'h4}, "reset pins");
        reg_read(ADDR_CTRL, rd);
        check(rd, 32'(CTRL_RST), "ctrl reset");
        reg_read(ADDR_MASK, rd);
        check(rd, 0, "mask reset");
        reg_read(ADDR_STS, rd);
        check(rd, 0, "status reset");
        reg_read(8'h10, rd);
        check(rd, 0, "unmapped");
        reg_write(ADDR_MASK, 32'h1);
        for (int i = 0; i < 7; i++)
            run_conv(rows[i], 1'b0, 1'b1);
        run_conv('{4'hC, 1'b1, 1'b1, 12'h5A5, 12'hA5A}, 1'b1, 1'b1);
        reg_write(ADDR_MASK, 32'h0);
        run_conv('{4'hC, 1'b0, 1'b0, 12'h7FF, 12'h000}, 1'b0, 1'b0);
        pulse_go();
        wait_status(1'b1, 10);
        repeat (50) @(posedge clk);
        resetn <= 1'b0;
        @(negedge clk);
        check({data_n, status}, {12'hFFF, 1'b0}, "mid-run reset");
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        reg_read(ADDR_STS, rd);
        check(rd, 0, "status after reset");
        tally_and_finish();
    end
endmodule
`default_nettype wire
